// >>> hdl/tsa_stage_attr.sv
// How it works
// - Sixteen attribute copies; stage selector 00h-0Fh routes each write.
// - Six face bases hold address bits 31:8, 256-byte aligned.
// - Force-miss bit 23 set makes every cache lookup of the stage miss.
// - Face location fields: 00 local, 01 dynamic buffer, 10/11 reserved.
// - Base mode 0: offset is level base; 1: face base plus offset.
// - Kind bits 11:8: 0001 2D, 0010 volume, 0011 cube, 1xxx projection.
// - Location: own face if base mode or pow2, else per-level choice.
// - Level-0 height and width up to 2048; levels are right shifts.
// - Volume length up to 2048; volumes get no mip reduction.
// - Bit 17 linear or tiled; bit 16 selects 8 or 16 high tiles.
// - Bit 15 flags power-of-two width and height.
// - Length, height, width exponents in 11:8, 7:4, 3:0, at most 11.
// - Colour extend replicate or zero; alpha replicates; raw video zero-fills.
// - Bit 14 puts first packed texel in low or high byte bits.
// - Depth modes 000, 010, 100, 110 map depth to output channels.
// - Odd depth modes compare depth to R with ge, gt, le, lt.
// - Non-compare depth converts to float with 7-bit exponent, 16-bit mantissa.
// - Depth border colour always comes from four border registers.
// - sRGB bit 8 enables de-gamma table on RGB after filtering.
// - Video mode 00 RGB, 01 SD matrix, 10 HD matrix, 11 table.
`timescale 1ns/1ps
`default_nettype none
module tsa_stage_attr
   import tsa_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Command write port
   input wire logic cmd_wr,
   input wire logic [7:0] parameter_class,
   input wire logic [7:0] stage_selector,
   input wire logic [31:0] cmd_word,
   // Readback port
   input wire logic [3:0] rd_stage,
   input wire logic [7:0] rd_sub,
   output logic [23:0] rd_data,
   // Fetch lookup from pipeline
   input wire logic [3:0] fetch_stage,
   input wire logic [2:0] fetch_face,
   input wire logic [3:0] fetch_level,
   input wire logic [23:0] level_offset,
   input wire logic cache_tag_hit,
   output logic cache_hit,
   output logic [1:0] fetch_location,
   output logic [23:0] level_base,
   output logic [11:0] level_width,
   output logic [11:0] level_height,
   output logic [11:0] level_length,
   output logic [1:0] texture_kind,
   output logic kind_valid,
   output logic memory_layout,
   output logic tall_tile_select,
   output logic pow2_flag,
   output logic dims_legal,
   output logic colour_extend_mode,
   output logic packed_texel_order,
   output logic degamma_enable,
   output logic [1:0] video_conversion_mode,
   // Depth texel path
   input wire logic depth_valid,
   input wire logic [23:0] depth_value,
   input wire logic [23:0] coord_r,
   input wire logic [11:0] border_red,
   input wire logic [11:0] border_green,
   input wire logic [11:0] border_blue,
   input wire logic [11:0] border_alpha,
   output logic [23:0] depth_float,
   output logic depth_cmp_true,
   output logic [2:0] depth_format_mode,
   output logic depth_is_shadow,
   output logic [3:0] chan_is_depth,
   output logic [3:0] chan_is_one,
   output logic [47:0] depth_border,
   output logic video_zero_fill,
   output logic alpha_replicate
);
   // ****************************************
   // Stage storage
   // ****************************************
   // Flat arrays keep readback a plain mux; sixteen stages of eleven words is small
   logic [23:0] face_base_r [STAGES][6];
   logic [23:0] loc_mode_r [STAGES];
   logic [23:0] l0_hw_r [STAGES];
   logic [23:0] l0_len_r [STAGES];
   logic [23:0] lay_exp_r [STAGES];
   logic [23:0] fmt_r [STAGES];

   // ****************************************
   // Write decode
   // ****************************************
   wire logic [7:0] wr_sub = cmd_word[CMD_SUB_HI:CMD_SUB_LO];
   wire logic [23:0] wr_val = cmd_word[DATA_W-1:0];
   wire logic wr_ok = cmd_wr && parameter_class == CLASS_TEX_STAGE
      && stage_selector <= STAGE_SEL_MAX;
   wire logic [3:0] wr_stage = stage_selector[STAGE_W-1:0];
   wire logic wr_base = wr_sub <= SA_FACE5_BASE;
   wire logic [2:0] wr_face = wr_sub[2:0];

   // One register set per stage; only the selected stage sees the strobe
   genvar gs;
   generate
      for (gs = 0; gs < STAGES; gs++) begin : g_stage
         wire logic hit = wr_ok && wr_stage == STAGE_W'(gs);
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               for (int f = 0; f < 6; f++) begin
                  face_base_r[gs][f] <= RESET_VAL;
               end
               loc_mode_r[gs] <= RESET_VAL;
               l0_hw_r[gs] <= RESET_VAL;
               l0_len_r[gs] <= RESET_VAL;
               lay_exp_r[gs] <= RESET_VAL;
               fmt_r[gs] <= RESET_VAL;
            end else if (hit) begin
               // Unknown sub-addresses fall through untouched
               if (wr_base) begin
                  face_base_r[gs][wr_face] <= wr_val & MASK_BASE;
               end
               if (wr_sub == SA_LOC_MODE) begin
                  loc_mode_r[gs] <= wr_val & MASK_LOC_MODE;
               end
               if (wr_sub == SA_L0_HW) begin
                  l0_hw_r[gs] <= wr_val & MASK_L0_HW;
               end
               if (wr_sub == SA_L0_LEN) begin
                  l0_len_r[gs] <= wr_val & MASK_L0_LEN;
               end
               if (wr_sub == SA_LAYOUT_EXP) begin
                  lay_exp_r[gs] <= wr_val & MASK_LAYOUT_EXP;
               end
               if (wr_sub == SA_FMT_CONV) begin
                  fmt_r[gs] <= wr_val & MASK_FMT_CONV;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Readback
   // ****************************************
   // Unmapped sub-addresses and reserved bits read as zero
   wire logic [23:0] rd_nxt =
      (rd_sub <= SA_FACE5_BASE) ? face_base_r[rd_stage][rd_sub[2:0]] :
      (rd_sub == SA_LOC_MODE) ? loc_mode_r[rd_stage] :
      (rd_sub == SA_L0_HW) ? l0_hw_r[rd_stage] :
      (rd_sub == SA_L0_LEN) ? l0_len_r[rd_stage] :
      (rd_sub == SA_LAYOUT_EXP) ? lay_exp_r[rd_stage] :
      (rd_sub == SA_FMT_CONV) ? fmt_r[rd_stage] : RESET_VAL;

   // ****************************************
   // Fetch-side decode
   // ****************************************
   wire logic [23:0] lm = loc_mode_r[fetch_stage];
   wire logic [23:0] hw = l0_hw_r[fetch_stage];
   wire logic [23:0] le = lay_exp_r[fetch_stage];
   wire logic [23:0] fm = fmt_r[fetch_stage];
   // Lookups read the stage the pipeline names, not the one last written
   wire logic base_mode = lm[B_BASE_MODE];
   wire logic pow2 = le[B_POW2];
   wire logic [3:0] kind = lm[F_KIND_LO +: 4];
   wire logic is_volume = kind == KIND_VOLUME;
   // Face locations at 1:0,3:2,5:4,7:6,15:14,17:16
   wire logic [11:0] face_locs = {lm[17:14], lm[7:0]};
   wire logic [2:0] face_idx = (fetch_face > 3'd5) ? 3'd0 : fetch_face;
   wire logic [1:0] own_loc = face_locs[face_idx*2 +: 2];
   // Level-one and level-eight choices share face 1 and face 2 fields
   wire logic [1:0] level_one_location = lm[3:2];
   wire logic [1:0] level_eight_location = lm[5:4];
   wire logic [1:0] loc_nxt = (base_mode || pow2) ? own_loc :
      (fetch_level == 4'h0) ? face_locs[1:0] :
      (fetch_level <= LEVEL_ONE_MAX) ? level_one_location : level_eight_location;
   wire logic [23:0] face_base = face_base_r[fetch_stage][face_idx];
   wire logic [23:0] base_nxt = base_mode ? 24'(face_base + level_offset) : level_offset;
   wire logic [11:0] w0 = hw[11:0];
   wire logic [11:0] h0 = hw[23:12];
   wire logic [11:0] l0 = l0_len_r[fetch_stage][11:0];
   // Volumes keep full size at every level; the depth axis has no mip chain
   wire logic [3:0] mip = is_volume ? 4'h0 : fetch_level;
   wire logic legal_nxt = w0 <= DIM_MAX && h0 <= DIM_MAX && l0 <= DIM_MAX
      && le[11:8] <= EXP_MAX && le[7:4] <= EXP_MAX && le[3:0] <= EXP_MAX;
   logic [1:0] kind_nxt;
   always_comb begin
      kind_nxt = TSA_KIND_2D;
      if (kind[3]) kind_nxt = TSA_KIND_PROJ;
      else if (kind == KIND_VOLUME) kind_nxt = TSA_KIND_VOL;
      else if (kind == KIND_CUBE) kind_nxt = TSA_KIND_CUBE;
   end
   wire logic kvalid_nxt = kind[3] || kind == KIND_2D || kind == KIND_VOLUME || kind == KIND_CUBE;

   // ****************************************
   // Depth path
   // ****************************************
   wire logic [2:0] zmode = fm[F_ZMODE_LO +: 3];
   wire logic [1:0] vconv = fm[F_VCONV_LO +: 2];
   // Odd depth codes are the compare modes
   wire logic shadow = zmode[0];
   logic cmp;
   logic [3:0] is_d;
   logic [3:0] is_one;
   always_comb begin
      cmp = 1'b0;
      is_d = 4'h0;
      is_one = 4'h0;
      case (zmode)
         Z_CMP_GE: cmp = depth_value >= coord_r;
         Z_CMP_GT: cmp = depth_value > coord_r;
         Z_CMP_LE: cmp = depth_value <= coord_r;
         Z_CMP_LT: cmp = depth_value < coord_r;
         default: cmp = 1'b0;
      endcase
      // Channel order {A,B,G,R}
      case (zmode)
         Z_GREEN: begin
            is_d = 4'b0010;
            is_one = 4'b1000;
         end
         Z_LUMA: begin
            is_d = 4'b0111;
            is_one = 4'b1000;
         end
         Z_INTENS: is_d = 4'b1111;
         Z_ALPHA: is_d = 4'b1000;
         default: is_one = {1'b1, {3{cmp}}};
      endcase
   end
   // Float s[7].16: leading-one normalise of 24-bit fixed depth
   logic [4:0] lead;
   always_comb begin
      lead = 5'd0;
      for (int i = 0; i < 24; i++) begin
         if (depth_value[i]) lead = 5'(i);
      end
   end
   // Zero depth has no leading one; its exponent is forced to zero
   wire logic [23:0] norm = depth_value << (5'd23 - lead);
   wire logic [6:0] fexp = (depth_value == 24'h0) ? 7'h00 : 7'(7'd40 + lead);
   wire logic [23:0] float_nxt = shadow ? 24'h0 : {1'b0, fexp, norm[22:7]};

   // ****************************************
   // Readback register
   // ****************************************
   // Settled one cycle after the select, so readers never see a half-decoded mux
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= RESET_VAL;
      end else begin
         rd_data <= rd_nxt;
      end
   end

   // ****************************************
   // Cache and location outputs
   // ****************************************
   // Force-miss gates the tag result here, after the tag compare
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cache_hit <= 1'b0;
         fetch_location <= 2'h0;
         level_base <= RESET_VAL;
      end else begin
         cache_hit <= cache_tag_hit && !lm[B_FORCE_MISS];
         fetch_location <= loc_nxt;
         level_base <= base_nxt;
      end
   end

   // ****************************************
   // Level dimensions
   // ****************************************
   // Illegal sizes are flagged, not clipped; the fetch side decides
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_width <= 12'h0;
         level_height <= 12'h0;
         level_length <= 12'h0;
         dims_legal <= 1'b0;
      end else begin
         level_width <= w0 >> mip;
         level_height <= h0 >> mip;
         level_length <= l0;
         dims_legal <= legal_nxt;
      end
   end

   // ****************************************
   // Texture kind
   // ****************************************
   // Reserved codes still map to a kind; kind_valid tells them apart
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         texture_kind <= TSA_KIND_2D;
         kind_valid <= 1'b0;
      end else begin
         texture_kind <= kind_nxt;
         kind_valid <= kvalid_nxt;
      end
   end

   // ****************************************
   // Memory layout
   // ****************************************
   // Tall tiles mean nothing in linear layout, so that bit is masked
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         memory_layout <= 1'b0;
         tall_tile_select <= 1'b0;
         pow2_flag <= 1'b0;
      end else begin
         memory_layout <= le[B_MEM_LAYOUT];
         tall_tile_select <= le[B_MEM_LAYOUT] && le[B_TALL_TILE];
         pow2_flag <= pow2;
      end
   end

   // ****************************************
   // Colour handling
   // ****************************************
   // Zero fill is reported for raw video too, so the filter needs no mode decode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         colour_extend_mode <= 1'b0;
         video_zero_fill <= 1'b0;
         alpha_replicate <= 1'b0;
         packed_texel_order <= 1'b0;
         degamma_enable <= 1'b0;
         video_conversion_mode <= VC_RGB;
      end else begin
         colour_extend_mode <= fm[B_CEXT];
         video_zero_fill <= fm[B_CEXT] || vconv == VC_RGB;
         alpha_replicate <= 1'b1;
         packed_texel_order <= fm[B_PACK_ORDER];
         degamma_enable <= fm[B_DEGAMMA];
         video_conversion_mode <= vconv;
      end
   end

   // ****************************************
   // Depth results
   // ****************************************
   // Float and compare outputs idle at zero without a valid texel to keep the shader input quiet
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         depth_float <= 24'h0;
         depth_cmp_true <= 1'b0;
         depth_format_mode <= Z_GREEN;
         depth_is_shadow <= 1'b0;
      end else begin
         depth_float <= depth_valid ? float_nxt : 24'h0;
         depth_cmp_true <= depth_valid && shadow && cmp;
         depth_format_mode <= zmode;
         depth_is_shadow <= shadow;
      end
   end

   // ****************************************
   // Channel map and border
   // ****************************************
   // Border passes through unchanged whatever the texture kind
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_is_depth <= 4'h0;
         chan_is_one <= 4'h0;
         depth_border <= 48'h0;
      end else begin
         chan_is_depth <= is_d;
         chan_is_one <= is_one;
         depth_border <= {border_alpha, border_blue, border_green, border_red};
      end
   end
endmodule // tsa_stage_attr
`default_nettype wire

// >>> pkg/tsa_pkg.sv
`default_nettype none
package tsa_pkg;
   // Command word layout
   localparam int CMD_SUB_HI = 31;
   localparam int CMD_SUB_LO = 24;
   localparam int DATA_W = 24;
   localparam int STAGES = 16;
   localparam int STAGE_W = 4;
   localparam logic [7:0] CLASS_TEX_STAGE = 8'h02;
   localparam logic [7:0] STAGE_SEL_MAX = 8'h0F;
   // Sub-addresses
   localparam logic [7:0] SA_FACE0_BASE = 8'h00;
   localparam logic [7:0] SA_FACE5_BASE = 8'h05;
   localparam logic [7:0] SA_LOC_MODE = 8'h18;
   localparam logic [7:0] SA_L0_HW = 8'h20;
   localparam logic [7:0] SA_L0_LEN = 8'h21;
   localparam logic [7:0] SA_LAYOUT_EXP = 8'h22;
   localparam logic [7:0] SA_FMT_CONV = 8'h30;
   // Writable-bit masks (reserved bits stay zero)
   localparam logic [23:0] MASK_BASE = 24'hFFFFFF;
   localparam logic [23:0] MASK_LOC_MODE = 24'h83DFFF;
   localparam logic [23:0] MASK_L0_HW = 24'hFFFFFF;
   localparam logic [23:0] MASK_L0_LEN = 24'h000FFF;
   localparam logic [23:0] MASK_LAYOUT_EXP = 24'h038FFF;
   localparam logic [23:0] MASK_FMT_CONV = 24'h00F903;
   localparam logic [23:0] RESET_VAL = 24'h000000;
   // Field positions
   localparam int B_FORCE_MISS = 23;
   localparam int B_BASE_MODE = 12;
   localparam int F_KIND_LO = 8;
   localparam int B_MEM_LAYOUT = 17;
   localparam int B_TALL_TILE = 16;
   localparam int B_POW2 = 15;
   localparam int B_CEXT = 15;
   localparam int B_PACK_ORDER = 14;
   localparam int F_ZMODE_LO = 11;
   localparam int B_DEGAMMA = 8;
   localparam int F_VCONV_LO = 0;
   localparam logic [11:0] DIM_MAX = 12'h800;
   localparam logic [3:0] EXP_MAX = 4'hB;
   localparam logic [3:0] LEVEL_ONE_MAX = 4'h7;
   // Texture kinds
   localparam logic [3:0] KIND_2D = 4'h1;
   localparam logic [3:0] KIND_VOLUME = 4'h2;
   localparam logic [3:0] KIND_CUBE = 4'h3;
   // Depth modes
   localparam logic [2:0] Z_GREEN = 3'h0;
   localparam logic [2:0] Z_LUMA = 3'h2;
   localparam logic [2:0] Z_INTENS = 3'h4;
   localparam logic [2:0] Z_ALPHA = 3'h6;
   localparam logic [2:0] Z_CMP_GE = 3'h1;
   localparam logic [2:0] Z_CMP_GT = 3'h3;
   localparam logic [2:0] Z_CMP_LE = 3'h5;
   localparam logic [2:0] Z_CMP_LT = 3'h7;
   // Video conversion modes
   localparam logic [1:0] VC_RGB = 2'h0;
   localparam logic [1:0] VC_SD = 2'h1;
   localparam logic [1:0] VC_HD = 2'h2;
   localparam logic [1:0] VC_TABLE = 2'h3;
   localparam logic [11:0] ONE_S110 = 12'h400;
   typedef enum logic [1:0] {
      TSA_KIND_2D = 2'b00,
      TSA_KIND_VOL = 2'b01,
      TSA_KIND_CUBE = 2'b10,
      TSA_KIND_PROJ = 2'b11
   } tsa_kind_t;
endpackage
`default_nettype wire

// >>> tb/tsa_stage_attr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_stage_attr_chk
   import tsa_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Watched ports
   input wire logic [7:0] rd_sub,
   input wire logic [23:0] rd_data,
   input wire logic cache_tag_hit,
   input wire logic cache_hit,
   input wire logic memory_layout,
   input wire logic tall_tile_select,
   input wire logic [11:0] border_red,
   input wire logic [11:0] border_green,
   input wire logic [11:0] border_blue,
   input wire logic [11:0] border_alpha,
   input wire logic [47:0] depth_border,
   input wire logic [23:0] depth_float,
   input wire logic [2:0] depth_format_mode,
   input wire logic depth_is_shadow,
   input wire logic colour_extend_mode,
   input wire logic [1:0] video_conversion_mode,
   input wire logic video_zero_fill,
   input wire logic alpha_replicate
);
   // Outputs still hold reset values at the first edge after release
   logic up_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         up_r <= 1'b0;
      end else begin
         up_r <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_hit_cause: assert property (cache_hit |-> $past(cache_tag_hit))
      else $error("cache hit without tag hit");
   chk_tile_gate: assert property (tall_tile_select |-> memory_layout)
      else $error("tall tiles in linear layout");
   chk_shadow_float: assert property (depth_is_shadow |-> depth_float == 24'h000000)
      else $error("float output in compare mode");
   chk_shadow_code: assert property (up_r |-> depth_is_shadow == depth_format_mode[0])
      else $error("compare flag disagrees with depth mode");
   chk_alpha_repl: assert property (up_r |-> alpha_replicate)
      else $error("alpha not replicated");
   chk_zero_fill: assert property (up_r |->
      video_zero_fill == (colour_extend_mode || video_conversion_mode == 2'h0))
      else $error("zero fill wrong");
   chk_border_path: assert property (up_r |->
      depth_border == $past({border_alpha, border_blue, border_green, border_red}))
      else $error("border not taken from component inputs");
   chk_rsvd_read: assert property (up_r && rd_sub inside {[8'h06:8'h17]} |=> rd_data == 24'h000000)
      else $error("reserved sub-address reads nonzero");
endmodule // tsa_stage_attr_chk
bind tsa_stage_attr tsa_stage_attr_chk tsa_stage_attr_chk_inst (.*);
`default_nettype wire

// >>> tb/tsa_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_pipe_model
   import tsa_pkg::*;
(
   // Lookup requests
   output logic [3:0] fetch_stage,
   output logic [2:0] fetch_face,
   output logic [3:0] fetch_level,
   output logic [23:0] level_offset,
   output logic cache_tag_hit,
   // Depth texels
   output logic depth_valid,
   output logic [23:0] depth_value,
   output logic [23:0] coord_r,
   output logic [11:0] border_red,
   output logic [11:0] border_green,
   output logic [11:0] border_blue,
   output logic [11:0] border_alpha
);
   initial begin
      {fetch_stage, fetch_face, fetch_level, level_offset, cache_tag_hit} = '0;
      {depth_valid, depth_value, coord_r} = '0;
      {border_alpha, border_blue, border_green, border_red} = 48'h0;
   end
   // Faces above 5 are never requested
   task automatic look(input logic [3:0] st, input logic [2:0] fc, input logic [3:0] lv,
                       input logic [23:0] off, input logic hit);
      {fetch_stage, fetch_face, fetch_level, level_offset, cache_tag_hit} = {st, fc, lv, off, hit};
   endtask
   task automatic depth(input logic [23:0] z, input logic [23:0] r, input logic [47:0] brd);
      {depth_valid, depth_value, coord_r} = {1'b1, z, r};
      {border_alpha, border_blue, border_green, border_red} = brd;
   endtask
endmodule // tsa_pipe_model
`default_nettype wire

// >>> tb/tb_tsa_stage_attr.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_tsa_stage_attr;
   import tsa_pkg::*;
   logic clk, rst_b, cmd_wr, cache_tag_hit, depth_valid, cache_hit, kind_valid, memory_layout;
   logic tall_tile_select, pow2_flag, dims_legal, colour_extend_mode, packed_texel_order, degamma_enable;
   logic depth_cmp_true, depth_is_shadow, video_zero_fill, alpha_replicate;
   logic [7:0] parameter_class, stage_selector, rd_sub;
   logic [31:0] cmd_word;
   logic [3:0] rd_stage, fetch_stage, fetch_level, chan_is_depth, chan_is_one;
   logic [2:0] fetch_face, depth_format_mode;
   logic [23:0] rd_data, level_offset, level_base, depth_value, coord_r, depth_float;
   logic [11:0] border_red, border_green, border_blue, border_alpha, level_width, level_height, level_length;
   logic [1:0] fetch_location, texture_kind, video_conversion_mode, vv;
   logic [47:0] depth_border;
   logic [2:0] m;
   int err_total, num_checks;
   logic [7:0] sas[10] = '{8'h00, 8'h05, 8'h18, 8'h20, 8'h21, 8'h22, 8'h30, 8'h06, 8'h19, 8'h23};
   logic [23:0] msk[10] = '{24'hFFFFFF, 24'hFFFFFF, 24'h83DFFF, 24'hFFFFFF, 24'h000FFF, 24'h038FFF,
                             24'h00F903, 24'h0, 24'h0, 24'h0};
   logic [3:0] kc[6] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'hF, 4'h4};
   logic [1:0] kx[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
   logic [3:0] cd[4] = '{4'h2, 4'h7, 4'hF, 4'h8};
   logic [3:0] co[4] = '{4'h8, 4'h8, 4'h0, 4'h0};
   logic [7:0] cx[2] = '{8'h22, 8'h0A};
   tsa_stage_attr tsa_stage_attr_inst (.*);
   tsa_pipe_model tsa_pipe_model_inst (.*);
   always #4 clk = ~clk;
   // ******************************
   // Access tasks
   // ******************************
   // The strobe stays high until step() lowers it, so writes may run back to back
   task automatic wr(input logic [7:0] st, input logic [7:0] sa, input logic [23:0] d,
                     input logic [7:0] cls = CLASS_TEX_STAGE);
      {cmd_wr, parameter_class, stage_selector, cmd_word} = {1'b1, cls, st, sa, d};
      @(posedge clk);
      #1;
   endtask
   task automatic step;
      cmd_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rdc(input logic [3:0] st, input logic [7:0] sa, input logic [23:0] e);
      {rd_stage, rd_sub} = {st, sa};
      step();
      `CHK(rd_data, e)
   endtask
   task automatic lk(input logic [3:0] st, input logic [2:0] fc, input logic [3:0] lv, input logic hit);
      tsa_pipe_model_inst.look(st, fc, lv, 24'h000020, hit);
      step();
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end
   // ******************************
   // Tests
   // ******************************
   initial begin
      {clk, rst_b, cmd_wr, parameter_class, stage_selector, cmd_word, rd_stage, rd_sub} = '0;
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      foreach (sas[i]) rdc(4'h3, sas[i], 24'h0);
      wr(8'h00, SA_FACE0_BASE, 24'hA5A5A5);
      wr(8'h0F, SA_FACE0_BASE, 24'h5A5A5A);
      wr(8'h10, SA_FACE0_BASE, 24'h111111);
      wr(8'h05, SA_FACE0_BASE, 24'h222222, 8'h01);
      rdc(4'h0, SA_FACE0_BASE, 24'hA5A5A5);
      rdc(4'hF, SA_FACE0_BASE, 24'h5A5A5A);
      rdc(4'h5, SA_FACE0_BASE, 24'h0);
      foreach (sas[i]) begin
         wr(8'h07, sas[i], 24'hFFFFFF);
         rdc(4'h7, sas[i], msk[i]);
      end
      wr(8'h02, SA_LOC_MODE, 24'h800000);
      lk(4'h2, 3'h0, 4'h0, 1'b1);
      `CHK(cache_hit, 1'b0)
      wr(8'h02, SA_LOC_MODE, 24'h000000);
      lk(4'h2, 3'h0, 4'h0, 1'b1);
      `CHK(cache_hit, 1'b1)
      foreach (kc[i]) begin
         wr(8'h04, SA_LOC_MODE, {12'h0, kc[i], 8'h0});
         lk(4'h4, 3'h0, 4'h0, 1'b0);
         `CHK(kind_valid, i < 5)
         if (i < 5) `CHK(texture_kind, kx[i])
      end
      wr(8'h06, SA_LOC_MODE, 24'h000004);
      wr(8'h06, 8'h01, 24'h000100);
      lk(4'h6, 3'h1, 4'h0, 1'b0);
      `CHK({fetch_location, level_base}, {2'h0, 24'h000020})
      lk(4'h6, 3'h1, 4'h7, 1'b0);
      `CHK(fetch_location, 2'h1)
      lk(4'h6, 3'h1, 4'h8, 1'b0);
      `CHK(fetch_location, 2'h0)
      wr(8'h06, SA_LOC_MODE, 24'h011004);
      lk(4'h6, 3'h1, 4'h9, 1'b0);
      `CHK({fetch_location, level_base}, {2'h1, 24'h000120})
      lk(4'h6, 3'h5, 4'h0, 1'b0);
      `CHK(fetch_location, 2'h1)
      wr(8'h06, SA_LOC_MODE, 24'h000004);
      wr(8'h06, SA_LAYOUT_EXP, 24'h008000);
      lk(4'h6, 3'h1, 4'h9, 1'b0);
      `CHK(fetch_location, 2'h1)
      wr(8'h08, SA_L0_HW, 24'h800400);
      wr(8'h08, SA_L0_LEN, 24'h000800);
      wr(8'h08, SA_LOC_MODE, 24'h000100);
      lk(4'h8, 3'h0, 4'h2, 1'b0);
      `CHK({level_height, level_width, level_length, dims_legal}, {36'h200100800, 1'b1})
      wr(8'h08, SA_LOC_MODE, 24'h000200);
      lk(4'h8, 3'h0, 4'h2, 1'b0);
      `CHK({level_height, level_width, level_length}, 36'h800400800)
      wr(8'h08, SA_L0_HW, 24'h800801);
      lk(4'h8, 3'h0, 4'h0, 1'b0);
      `CHK(dims_legal, 1'b0)
      wr(8'h09, SA_LAYOUT_EXP, 24'h038BBB);
      lk(4'h9, 3'h0, 4'h0, 1'b0);
      `CHK({memory_layout, tall_tile_select, pow2_flag, dims_legal}, 4'hF)
      wr(8'h09, SA_LAYOUT_EXP, 24'h010C00);
      lk(4'h9, 3'h0, 4'h0, 1'b0);
      `CHK({memory_layout, tall_tile_select, pow2_flag, dims_legal}, 4'h0)
      for (int v = 0; v < 4; v++) begin
         vv = 2'(v);
         wr(8'h0A, SA_FMT_CONV, {8'h00, vv[0], vv[1], 5'h00, ~vv[1], 6'h00, vv});
         lk(4'hA, 3'h0, 4'h0, 1'b0);
         `CHK({colour_extend_mode, packed_texel_order, degamma_enable}, {vv[0], vv[1], ~vv[1]})
         `CHK({video_conversion_mode, video_zero_fill}, {vv, vv[0] | (vv == 2'h0)})
      end
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            m = 3'(k);
            wr(8'h0B, SA_FMT_CONV, {10'h000, m, 11'h000});
            tsa_pipe_model_inst.depth(24'h000100 << p, 24'h000100, {12'h123 + 12'(k), 36'hABC456789});
            lk(4'hB, 3'h0, 4'h0, 1'b0);
            `CHK({depth_format_mode, depth_is_shadow}, {m, m[0]})
            `CHK(depth_border, {12'h123 + 12'(k), 36'hABC456789})
            if (m[0]) `CHK({depth_float, depth_cmp_true}, {24'h0, cx[p][k]})
            else `CHK({depth_float, chan_is_depth, chan_is_one}, {8'h30 + 8'(p), 16'h0, cd[k/2], co[k/2]})
         end
      end
      wrap_up();
   end
endmodule // tb_tsa_stage_attr
`default_nettype wire
